// *** rtl/tfs_pkg.sv ***
// Behaviour
// - Master clock 8.192 MHz drives frame timing
// - Input edge select picks frame boundary edge
// - Frame pulse 122 ns, or 244 ns
// - Frame pulse style detected automatically
// - Drive generated 8.192 MHz output clock
// - Output edge select aligns clocks to boundary
// - 8 kHz frame pulse, 122/244 ns wide
// - Output pulses copy detected input style
// - Drive generated 16.384 MHz output clock
// - Second frame pulse 61/122 ns wide
// - Serial outputs launched on output timing
// - Streams 0-15: 256 or 128 channels
// - Streams 16-31 ignored at high rate
package tfs_pkg;
  // Master clock rate and period
  localparam int MCLK_KHZ         = 8192;
  localparam int MCLK_PERIOD_NS   = 1000000 / MCLK_KHZ;
  localparam int QUARTERS_PER_MCLK = 4;
  // Frame pulse widths as printed
  localparam int FP8_NARROW_NS    = 122;
  localparam int FP8_WIDE_NS      = 244;
  localparam int FP16_NARROW_NS   = 61;
  localparam int FP16_WIDE_NS     = 122;
  // Widths in master periods and in quarter periods
  localparam int FP_NARROW_MCLK   = FP8_NARROW_NS / MCLK_PERIOD_NS;
  localparam int FP_WIDE_MCLK     = FP8_WIDE_NS / MCLK_PERIOD_NS;
  localparam int FP8_NARROW_Q     = FP8_NARROW_NS * QUARTERS_PER_MCLK / MCLK_PERIOD_NS;
  localparam int FP8_WIDE_Q       = FP8_WIDE_NS * QUARTERS_PER_MCLK / MCLK_PERIOD_NS;
  localparam int FP16_NARROW_Q    = FP16_NARROW_NS * QUARTERS_PER_MCLK / MCLK_PERIOD_NS;
  localparam int FP16_WIDE_Q      = FP16_WIDE_NS * QUARTERS_PER_MCLK / MCLK_PERIOD_NS;
  // Frame geometry
  localparam int CHANNEL_BITS     = 8;
  localparam int CH_FAST          = 256;
  localparam int CH_SLOW          = 128;
  localparam int FRAME_BITS_FAST  = CH_FAST * CHANNEL_BITS;
  localparam int FRAME_BITS_SLOW  = CH_SLOW * CHANNEL_BITS;
  localparam int STREAMS          = 32;
  localparam int FAST_STREAMS     = 16;
  // Idle run length that marks the pulse's idle level
  localparam int IDLE_RUN_MCLK    = 4;
  // Reset value and fast rate lane mask
  localparam int HALF_LEN_RST     = 4;
  localparam logic [63:0] FAST_LANE_MASK = 64'h0000FFFF0000FFFF;

  typedef enum logic [0:0] {
    TFS_HUNT = 1'b0,
    TFS_LOCK = 1'b1
  } tfs_sync_t;

  // Style a: idle high, active low; style b: idle low, active high
  typedef enum logic [0:0] {
    TFS_STYLE_A = 1'b0,
    TFS_STYLE_B = 1'b1
  } tfs_style_t;
endpackage

// *** rtl/tfs_word_if.sv ***
`timescale 1ns/10ps
interface tfs_word_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// *** rtl/tfs_word_buf.sv ***
`timescale 1ns/10ps
module tfs_word_buf #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  // Filling side
  tfs_word_if.snk           fill,
  // Draining side
  output logic              drain_valid_out,
  input  wire logic         drain_ready_in,
  output logic [W-1:0]      drain_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;
  logic          push;
  logic          pop;

  // Honest full and empty from the entry count
  assign fill.ready      = (count_q != CW'(DEPTH));
  assign drain_valid_out = (count_q != '0);
  assign drain_data_out  = mem_q[rd_ptr_q];
  assign push            = fill.valid & fill.ready;
  assign pop             = drain_valid_out & drain_ready_in;

  // Storage written only on accepted pushes
  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= fill.data;
    end
  end

  // Pointers and count
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// *** rtl/tfs_frame_timing.sv ***
`timescale 1ns/10ps
module tfs_frame_timing #(
  parameter int STREAMS = tfs_pkg::STREAMS,
  parameter int DEPTH   = 2
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  // Timing source pins
  input  wire logic                 master_clock_in,
  input  wire logic                 frame_pulse_in,
  // Static configuration
  input  wire logic                 input_clock_edge_select_in,
  input  wire logic                 output_clock_edge_select_in,
  input  wire logic                 frame_pulse_width_select_in,
  input  wire logic                 rate_16m_select_in,
  // Serial stream pins
  input  wire logic [STREAMS-1:0]   backplane_serial_in,
  input  wire logic [STREAMS-1:0]   local_serial_in,
  output logic      [STREAMS-1:0]   backplane_serial_out,
  output logic      [STREAMS-1:0]   local_serial_out,
  // Generated timing
  output logic                      clk8_out,
  output logic                      frame_pulse8_out,
  output logic                      clk16_out,
  output logic                      frame_pulse16_out,
  output logic                      pulse_style_out,
  output logic                      locked_out,
  // Received channel words
  output logic                      rx_valid_out,
  input  wire logic                 rx_ready_in,
  output logic      [7:0]           rx_channel_out,
  output logic      [8*STREAMS-1:0] rx_backplane_out,
  output logic      [8*STREAMS-1:0] rx_local_out,
  output logic                      overrun_out,
  // Transmit channel words
  input  wire logic [8*STREAMS-1:0] tx_backplane_in,
  input  wire logic [8*STREAMS-1:0] tx_local_in,
  output logic                      tx_load_out
);
  localparam int NS = 2 * STREAMS;
  localparam int WW = 8 + 8 * NS;

  logic [2:0]          mclk_s_q;
  logic [1:0]          fp_s_q;
  logic [NS-1:0]       ser_s1_q;
  logic [NS-1:0]       ser_s2_q;
  logic                rise;
  logic                fall;
  logic                act_edge;
  logic                opp_edge;
  logic                mid_tick;
  logic                quarter_tick;
  logic [7:0]          ph_cnt_q;
  logic [7:0]          half_len_q;
  logic                fp_last_q;
  logic [2:0]          run_q;
  logic                idle_lvl_q;
  logic                style_known_q;
  logic [1:0]          asrt_q;
  logic                asserted;
  logic                in_boundary;
  logic [1:0]          width_mclk;
  tfs_pkg::tfs_sync_t  state_q;
  tfs_pkg::tfs_style_t style_q;
  logic [10:0]         bit_cnt_q;
  logic [10:0]         cur_bit;
  logic [10:0]         last_bit;
  logic                bit_tick;
  logic                frame_tick;
  logic [NS-1:0]       lane_mask;
  logic [NS-1:0]       ser_val;
  logic [7:0]          rx_sh_q [NS];
  logic [7:0]          tx_sh_q [NS];
  logic [NS-1:0]       ser_out_q;
  logic [NS-1:0]       ser_idle;
  logic [WW-1:0]       word_d;
  logic [WW-1:0]       word_q;
  logic                push_q;
  logic                overrun_q;
  logic [3:0]          fp8_cnt_q;
  logic [3:0]          fp16_cnt_q;
  logic                fp8_q;
  logic                fp16_q;
  logic                clk8_q;
  logic                clk16_q;
  logic [WW-1:0]       drain_data;
  logic [8*NS-1:0]     tx_all;

  tfs_word_if #(.W(WW)) fill_if ();

  // Two-flop synchronisers, third master clock flop for edge finding
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mclk_s_q <= '0;
      fp_s_q   <= '0;
      ser_s1_q <= '0;
      ser_s2_q <= '0;
    end else begin
      mclk_s_q <= {mclk_s_q[1:0], master_clock_in};
      fp_s_q   <= {fp_s_q[0], frame_pulse_in};
      ser_s1_q <= {local_serial_in, backplane_serial_in};
      ser_s2_q <= ser_s1_q;
    end
  end

  // Edges of the master clock
  assign rise     = mclk_s_q[1] & ~mclk_s_q[2];
  assign fall     = ~mclk_s_q[1] & mclk_s_q[2];
  assign act_edge = input_clock_edge_select_in ? rise : fall;
  assign opp_edge = input_clock_edge_select_in ? fall : rise;

  // Half period measurement, gives mid points for the fast clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ph_cnt_q   <= '0;
      half_len_q <= 8'(tfs_pkg::HALF_LEN_RST);
    end else if (rise | fall) begin
      half_len_q <= ph_cnt_q + 8'h01;
      ph_cnt_q   <= '0;
    end else if (ph_cnt_q != 8'hFF) begin
      ph_cnt_q <= ph_cnt_q + 8'h01;
    end
  end

  assign mid_tick     = ~(rise | fall) && ((ph_cnt_q + 8'h01) == (half_len_q >> 1));
  assign quarter_tick = rise | fall | mid_tick;

  // Idle level and pulse run tracking on each active edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fp_last_q     <= 1'b1;
      run_q         <= '0;
      idle_lvl_q    <= 1'b1;
      style_known_q <= 1'b0;
      asrt_q        <= '0;
    end else if (act_edge) begin
      fp_last_q <= fp_s_q[1];
      if (fp_s_q[1] != fp_last_q) begin
        run_q <= 3'h1;
      end else if (run_q != 3'h7) begin
        run_q <= run_q + 3'h1;
      end
      if (fp_s_q[1] == fp_last_q && run_q >= 3'(tfs_pkg::IDLE_RUN_MCLK - 1)) begin
        idle_lvl_q    <= fp_s_q[1];
        style_known_q <= 1'b1;
      end
      asrt_q <= asserted ? ((asrt_q == 2'h3) ? asrt_q : asrt_q + 2'h1) : 2'h0;
    end
  end

  assign style_q     = idle_lvl_q ? tfs_pkg::TFS_STYLE_A : tfs_pkg::TFS_STYLE_B;
  assign asserted    = (fp_s_q[1] != idle_lvl_q);
  assign width_mclk  = frame_pulse_width_select_in ? 2'(tfs_pkg::FP_WIDE_MCLK)
                                                   : 2'(tfs_pkg::FP_NARROW_MCLK);
  assign in_boundary = act_edge & style_known_q & asserted & ((asrt_q + 2'h1) == width_mclk);

  // Frame lock: hunt for a pulse, then flywheel and realign
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= tfs_pkg::TFS_HUNT;
    end else begin
      case (state_q)
        tfs_pkg::TFS_HUNT: begin
          if (in_boundary) begin
            state_q <= tfs_pkg::TFS_LOCK;
          end
        end
        tfs_pkg::TFS_LOCK: begin
          if (!style_known_q) begin
            state_q <= tfs_pkg::TFS_HUNT;
          end
        end
        default: begin
          state_q <= tfs_pkg::TFS_HUNT;
        end
      endcase
    end
  end

  // Bit ticks: one per master period slow, one per edge fast
  assign bit_tick   = ((state_q == tfs_pkg::TFS_LOCK) | in_boundary) &
                      (rate_16m_select_in ? (rise | fall) : act_edge);
  assign cur_bit    = in_boundary ? 11'h000 : bit_cnt_q;
  assign last_bit   = rate_16m_select_in ? 11'(tfs_pkg::FRAME_BITS_FAST - 1)
                                         : 11'(tfs_pkg::FRAME_BITS_SLOW - 1);
  assign frame_tick = bit_tick & (cur_bit == 11'h000);

  // Bit position within the frame
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bit_cnt_q <= '0;
    end else if (bit_tick) begin
      bit_cnt_q <= (cur_bit >= last_bit) ? 11'h000 : cur_bit + 11'h001;
    end
  end

  // Upper streams are ignored at the fast rate
  assign lane_mask = rate_16m_select_in ? tfs_pkg::FAST_LANE_MASK[NS-1:0] : '1;
  assign ser_val   = ser_s2_q & lane_mask;
  assign ser_idle  = ~lane_mask;
  assign tx_all    = {tx_local_in, tx_backplane_in};

  // Completed channel word: number, then one byte per stream
  always_comb begin
    word_d = '0;
    word_d[WW-1 -: 8] = cur_bit[10:3];
    for (int i = 0; i < NS; i++) begin
      word_d[8*i +: 8] = {rx_sh_q[i][6:0], ser_val[i]};
    end
  end

  // Input shift registers, MSB first
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NS; i++) begin
        rx_sh_q[i] <= '0;
      end
    end else if (bit_tick) begin
      for (int i = 0; i < NS; i++) begin
        rx_sh_q[i] <= {rx_sh_q[i][6:0], ser_val[i]};
      end
    end
  end

  // Offer each channel to the buffer, flag a word that finds it still full
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      push_q    <= 1'b0;
      word_q    <= '0;
      overrun_q <= 1'b0;
    end else begin
      if (bit_tick && cur_bit[2:0] == 3'h7) begin
        push_q <= 1'b1;
        word_q <= word_d;
        if (push_q && !fill_if.ready) begin
          overrun_q <= 1'b1;
        end
      end else if (fill_if.ready) begin
        push_q <= 1'b0;
      end
    end
  end

  assign fill_if.valid = push_q;
  assign fill_if.data  = word_q;

  tfs_word_buf #(
    .W     (WW),
    .DEPTH (DEPTH)
  ) u_buf (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .fill            (fill_if),
    .drain_valid_out (rx_valid_out),
    .drain_ready_in  (rx_ready_in),
    .drain_data_out  (drain_data)
  );

  assign rx_channel_out   = drain_data[WW-1 -: 8];
  assign rx_local_out     = drain_data[16*STREAMS-1 : 8*STREAMS];
  assign rx_backplane_out = drain_data[8*STREAMS-1 : 0];
  assign overrun_out      = overrun_q;

  // Output shift registers launched on the output bit ticks
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ser_out_q <= '1;
      for (int i = 0; i < NS; i++) begin
        tx_sh_q[i] <= '0;
      end
    end else if (bit_tick) begin
      for (int i = 0; i < NS; i++) begin
        if (cur_bit[2:0] == 3'h0) begin
          ser_out_q[i] <= tx_all[8*i + 7] | ser_idle[i];
          tx_sh_q[i]   <= {tx_all[8*i +: 7], 1'b0};
        end else begin
          ser_out_q[i] <= tx_sh_q[i][7] | ser_idle[i];
          tx_sh_q[i]   <= {tx_sh_q[i][6:0], 1'b0};
        end
      end
    end
  end

  assign tx_load_out          = bit_tick & (cur_bit[2:0] == 3'h0);
  assign backplane_serial_out = ser_out_q[STREAMS-1:0];
  assign local_serial_out     = ser_out_q[NS-1:STREAMS];

  // Output clocks: active master edge sets the boundary edge
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      clk8_q  <= 1'b0;
      clk16_q <= 1'b0;
    end else begin
      if (act_edge) begin
        clk8_q  <= output_clock_edge_select_in;
        clk16_q <= output_clock_edge_select_in;
      end else if (opp_edge) begin
        clk8_q  <= ~output_clock_edge_select_in;
        clk16_q <= output_clock_edge_select_in;
      end else if (mid_tick) begin
        clk16_q <= ~output_clock_edge_select_in;
      end
    end
  end

  // Output frame pulses, counted in quarter master periods
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      fp8_cnt_q  <= '0;
      fp16_cnt_q <= '0;
      fp8_q      <= 1'b1;
      fp16_q     <= 1'b1;
    end else begin
      if (frame_tick) begin
        fp8_cnt_q  <= frame_pulse_width_select_in ? 4'(tfs_pkg::FP8_WIDE_Q)
                                                  : 4'(tfs_pkg::FP8_NARROW_Q);
        fp16_cnt_q <= frame_pulse_width_select_in ? 4'(tfs_pkg::FP16_WIDE_Q)
                                                  : 4'(tfs_pkg::FP16_NARROW_Q);
      end else if (quarter_tick) begin
        fp8_cnt_q  <= (fp8_cnt_q != 4'h0) ? fp8_cnt_q - 4'h1 : 4'h0;
        fp16_cnt_q <= (fp16_cnt_q != 4'h0) ? fp16_cnt_q - 4'h1 : 4'h0;
      end
      fp8_q  <= (frame_tick | (fp8_cnt_q > 4'h1) | ((fp8_cnt_q == 4'h1) & ~quarter_tick))
                ^ (style_q == tfs_pkg::TFS_STYLE_A);
      fp16_q <= (frame_tick | (fp16_cnt_q > 4'h1) | ((fp16_cnt_q == 4'h1) & ~quarter_tick))
                ^ (style_q == tfs_pkg::TFS_STYLE_A);
    end
  end

  assign clk8_out          = clk8_q;
  assign clk16_out         = clk16_q;
  assign frame_pulse8_out  = fp8_q;
  assign frame_pulse16_out = fp16_q;
  assign pulse_style_out   = style_q;
  assign locked_out        = (state_q == tfs_pkg::TFS_LOCK);
endmodule

// *** verif/tfs_frame_timing_chk.sv ***
`timescale 1ns/10ps
module tfs_frame_timing_chk #(
  parameter int STREAMS   = 32,
  parameter int Q_CYC     = 2,
  parameter int FRAME_CYC = 8192
) (
  // Clock, reset and configuration
  input wire logic               clk_in,
  input wire logic               rst_in,
  input wire logic               output_clock_edge_select_in,
  input wire logic               frame_pulse_width_select_in,
  input wire logic               rate_16m_select_in,
  input wire logic               rx_ready_in,
  // Observed outputs
  input wire logic [STREAMS-1:0] backplane_serial_out,
  input wire logic [STREAMS-1:0] local_serial_out,
  input wire logic               clk8_out,
  input wire logic               frame_pulse8_out,
  input wire logic               clk16_out,
  input wire logic               frame_pulse16_out,
  input wire logic               pulse_style_out,
  input wire logic               locked_out,
  input wire logic               rx_valid_out,
  input wire logic [7:0]         rx_channel_out,
  input wire logic               overrun_out,
  input wire logic               tx_load_out
);
  localparam int W8N  = tfs_pkg::FP8_NARROW_Q * Q_CYC;
  localparam int W8W  = tfs_pkg::FP8_WIDE_Q * Q_CYC;
  localparam int W16N = tfs_pkg::FP16_NARROW_Q * Q_CYC;
  localparam int W16W = tfs_pkg::FP16_WIDE_Q * Q_CYC;
  localparam int UP   = tfs_pkg::FAST_STREAMS;
  logic        act8;
  logic        act16;
  logic        wide;
  logic [5:0]  n8_q;
  logic [5:0]  n16_q;
  logic [15:0] gap_q;
  logic        p8_q;
  logic        seen_q;
  logic [7:0]  nxt_ch;

  // Active pulse levels once locked, and the channel expected next
  assign act8   = locked_out && (frame_pulse8_out == pulse_style_out);
  assign act16  = locked_out && (frame_pulse16_out == pulse_style_out);
  assign wide   = frame_pulse_width_select_in;
  assign nxt_ch = (rx_channel_out + 8'h01) & (rate_16m_select_in ? 8'hFF : 8'h7F);

  // Run lengths of both pulses
  always_ff @(posedge clk_in) begin
    n8_q  <= act8 ? n8_q + 6'h01 : 6'h00;
    n16_q <= act16 ? n16_q + 6'h01 : 6'h00;
    p8_q  <= act8;
  end

  // Cycles since the last frame pulse start
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      seen_q <= 1'b0;
      gap_q  <= 16'h0000;
    end else if (act8 && !p8_q) begin
      seen_q <= 1'b1;
      gap_q  <= 16'h0001;
    end else begin
      gap_q <= gap_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  fp8_width_a: assert property (
    $fell(act8) |-> n8_q == (wide ? W8W : W8N)) else $error("fp8 width wrong");
  fp16_width_a: assert property (
    $fell(act16) |-> n16_q == (wide ? W16W : W16N)) else $error("fp16 width wrong");
  pulse_pair_a: assert property (
    $rose(act8) |-> $rose(act16)) else $error("pulses start apart");
  edge_align_a: assert property (
    $rose(act8) |-> clk8_out == output_clock_edge_select_in
      && clk16_out == output_clock_edge_select_in) else $error("clock edge off boundary");
  frame_period_a: assert property (
    $rose(act8) && seen_q |-> gap_q == FRAME_CYC) else $error("frame length wrong");
  clk8_rate_a: assert property (
    locked_out && $changed(clk8_out) |=> $stable(clk8_out)[*3] ##1 $changed(clk8_out))
    else $error("clk8 half period wrong");
  clk16_rate_a: assert property (
    locked_out && $changed(clk16_out) |=> $stable(clk16_out) ##1 $changed(clk16_out))
    else $error("clk16 half period wrong");
  upper_idle_a: assert property (
    locked_out && rate_16m_select_in |-> &backplane_serial_out[STREAMS-1:UP]
      && &local_serial_out[STREAMS-1:UP]) else $error("upper stream not idle");
  rx_hold_a: assert property (
    rx_valid_out && !rx_ready_in |=> rx_valid_out
      && (overrun_out || $stable(rx_channel_out))) else $error("word dropped");
  rx_order_a: assert property (
    rx_valid_out && rx_ready_in && !overrun_out ##1 rx_valid_out && !overrun_out
      |-> rx_channel_out == $past(nxt_ch)) else $error("channel order wrong");
  tx_space_a: assert property (
    tx_load_out |=> !tx_load_out[*8]) else $error("load pulses too close");
endmodule

bind tfs_frame_timing tfs_frame_timing_chk #(.STREAMS(STREAMS)) u_tfs_frame_timing_chk (
  .clk_in, .rst_in, .output_clock_edge_select_in, .frame_pulse_width_select_in,
  .rate_16m_select_in, .rx_ready_in, .backplane_serial_out, .local_serial_out, .clk8_out,
  .frame_pulse8_out, .clk16_out, .frame_pulse16_out, .pulse_style_out, .locked_out,
  .rx_valid_out, .rx_channel_out, .overrun_out, .tx_load_out
);

// *** verif/tfs_source_model.sv ***
`timescale 1ns/10ps
module tfs_source_model (
  // Settings from the bench
  input  wire logic  style_b_in,
  input  wire logic  wide_in,
  input  wire logic  rising_in,
  input  wire logic  fast_in,
  // Timing source and framer pins
  output logic       master_clock_out,
  output logic       frame_pulse_out,
  output logic [31:0] backplane_out,
  output logic [31:0] local_out
);
  int         p;
  logic       act;
  logic [7:0] ch;
  logic [7:0] lb;

  // Free running clock; pulse and data move on the inactive edge
  initial begin
    p = 0;
    master_clock_out = 1'b0;
    frame_pulse_out = 1'b1;
    backplane_out = 32'h00000000;
    local_out = 32'h00000000;
    #37;
    forever begin
      master_clock_out = rising_in;
      #400;
      master_clock_out = ~rising_in;
      p = (p + 1) % 1024;
      act = (p == 0) || (wide_in && p == 1023);
      frame_pulse_out = act ~^ style_b_in;
      ch = 8'(p / 8);
      lb = ch ^ 8'hA5;
      if (fast_in) begin
        backplane_out = 32'hFFFFFFFF;
        local_out = 32'h00000000;
      end else begin
        backplane_out = {32{ch[7 - p % 8]}};
        local_out = {32{lb[7 - p % 8]}};
      end
      #400;
    end
  end
endmodule

// *** verif/tfs_frame_timing_bench.sv ***
`timescale 1ns/10ps
module tfs_frame_timing_bench;
  localparam int LIMIT = 80000;
  localparam int QC    = 2;
  logic         clk_in = 1'b0;
  logic         rst_in;
  logic         input_clock_edge_select_in;
  logic         output_clock_edge_select_in;
  logic         frame_pulse_width_select_in;
  logic         rate_16m_select_in;
  logic         rx_ready_in;
  logic         style_b;
  logic         master_clock_in;
  logic         frame_pulse_in;
  logic [31:0]  backplane_serial_in;
  logic [31:0]  local_serial_in;
  logic [31:0]  backplane_serial_out;
  logic [31:0]  local_serial_out;
  logic         clk8_out;
  logic         frame_pulse8_out;
  logic         clk16_out;
  logic         frame_pulse16_out;
  logic         pulse_style_out;
  logic         locked_out;
  logic         rx_valid_out;
  logic [7:0]   rx_channel_out;
  logic [255:0] rx_backplane_out;
  logic [255:0] rx_local_out;
  logic         overrun_out;
  logic [255:0] tx_backplane_in;
  logic [255:0] tx_local_in;
  logic         tx_load_out;
  int           miscompares;
  int           compares;
  int           cyc;

  tfs_frame_timing u_tfs_frame_timing (
    .clk_in, .rst_in, .master_clock_in, .frame_pulse_in, .input_clock_edge_select_in,
    .output_clock_edge_select_in, .frame_pulse_width_select_in, .rate_16m_select_in,
    .backplane_serial_in, .local_serial_in, .backplane_serial_out, .local_serial_out,
    .clk8_out, .frame_pulse8_out, .clk16_out, .frame_pulse16_out, .pulse_style_out,
    .locked_out, .rx_valid_out, .rx_ready_in, .rx_channel_out, .rx_backplane_out,
    .rx_local_out, .overrun_out, .tx_backplane_in, .tx_local_in, .tx_load_out
  );

  tfs_source_model u_tfs_source_model (
    .style_b_in(style_b), .wide_in(frame_pulse_width_select_in),
    .rising_in(input_clock_edge_select_in), .fast_in(rate_16m_select_in),
    .master_clock_out(master_clock_in), .frame_pulse_out(frame_pulse_in),
    .backplane_out(backplane_serial_in), .local_out(local_serial_in)
  );

  // System clock and run limit
  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      miscompares++;
      results();
    end
  end

  task automatic check(input string what, input logic [255:0] seen, input logic [255:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Reset with a new static setting
  task automatic restart(input logic s, w, i, o, r);
    rst_in <= 1'b1;
    style_b <= s;
    frame_pulse_width_select_in <= w;
    input_clock_edge_select_in <= i;
    output_clock_edge_select_in <= o;
    rate_16m_select_in <= r;
    rx_ready_in <= 1'b1;
    tx_backplane_in <= {32{8'hB4}};
    tx_local_in <= {32{8'h4B}};
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
  endtask

  // Lock, style, pulse widths, boundary edges and frame length
  task automatic frame_check(input logic s, w, o);
    int n8;
    int n16;
    int i;
    n8 = 0;
    n16 = 0;
    i = 0;
    while (locked_out !== 1'b1 && i < 20000) begin
      @(posedge clk_in);
      i++;
    end
    check("locked", locked_out, 1'b1);
    check("style", pulse_style_out, s);
    i = 0;
    while (frame_pulse8_out !== s && i < 9000) begin
      @(posedge clk_in);
      i++;
    end
    check("clk8 at boundary", clk8_out, o);
    check("clk16 at boundary", clk16_out, o);
    repeat (24) begin
      n8 += (frame_pulse8_out === s);
      n16 += (frame_pulse16_out === s);
      @(posedge clk_in);
    end
    check("fp8 width", n8, QC * (w ? tfs_pkg::FP8_WIDE_Q : tfs_pkg::FP8_NARROW_Q));
    check("fp16 width", n16, QC * (w ? tfs_pkg::FP16_WIDE_Q : tfs_pkg::FP16_NARROW_Q));
    i = 24;
    while (frame_pulse8_out !== s && i < 9000) begin
      @(posedge clk_in);
      i++;
    end
    check("frame length", i, 8 * tfs_pkg::FRAME_BITS_SLOW);
  endtask

  // Wait for the next tx load cycle
  task automatic wait_load();
    int i;
    i = 0;
    while (tx_load_out !== 1'b1 && i < 200) begin
      @(posedge clk_in);
      i++;
    end
    check("tx load", tx_load_out, 1'b1);
  endtask

  task automatic t_narrow_style_a();
    int k;
    int i;
    logic [7:0] b0;
    logic [7:0] b31;
    restart(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    frame_check(1'b0, 1'b0, 1'b0);
    k = 0;
    i = 0;
    while (k < 6 && i < 1000) begin
      @(posedge clk_in);
      i++;
      if (rx_valid_out === 1'b1) begin
        check("rx channel", rx_channel_out, k);
        check("rx backplane", rx_backplane_out[7:0], rx_channel_out);
        check("rx local", rx_local_out[255:248], rx_channel_out ^ 8'hA5);
        k++;
      end
    end
    check("rx words", k, 6);
    wait_load();
    for (k = 7; k >= 0; k--) begin
      repeat (k == 7 ? 1 : 8) @(posedge clk_in);
      b0[k] = backplane_serial_out[0];
      b31[k] = local_serial_out[31];
    end
    check("tx backplane", b0, 8'hB4);
    check("tx local", b31, 8'h4B);
    $display("t_narrow_style_a done");
  endtask

  task automatic t_wide_style_b_overrun();
    restart(1'b1, 1'b1, 1'b1, 1'b1, 1'b0);
    frame_check(1'b1, 1'b1, 1'b1);
    rx_ready_in <= 1'b0;
    repeat (150) @(posedge clk_in);
    check("no overrun", overrun_out, 1'b0);
    check("two held", rx_valid_out, 1'b1);
    rx_ready_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rx_ready_in <= 1'b0;
    repeat (300) @(posedge clk_in);
    check("overrun", overrun_out, 1'b1);
    check("word held", rx_valid_out, 1'b1);
    $display("t_wide_style_b_overrun done");
  endtask

  task automatic t_fast_rate();
    int i;
    restart(1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    frame_check(1'b1, 1'b0, 1'b1);
    check("upper outs", backplane_serial_out[31:16], 16'hFFFF);
    i = 0;
    while (rx_valid_out !== 1'b1 && i < 200) begin
      @(posedge clk_in);
      i++;
    end
    check("rx low streams", rx_backplane_out[127:0], {16{8'hFF}});
    check("rx high streams", rx_backplane_out[255:128], 128'h0);
    check("rx local", rx_local_out, 256'h0);
    wait_load();
    @(posedge clk_in);
    check("tx fast backplane", backplane_serial_out[15:0], 16'hFFFF);
    check("tx fast local", local_serial_out[15:0], 16'h0000);
    $display("t_fast_rate done");
  endtask

  initial begin
    miscompares = 0;
    compares = 0;
    cyc = 0;
    t_narrow_style_a();
    t_wide_style_b_overrun();
    t_fast_rate();
    results();
  end
endmodule
